// File: fhk_housekeeping.sv
// twelve-fibre housekeeping: coarse calibration, thresholds, tick monitor
// assumes sample inputs and fine-pass writes synchronous to i_sys_clk
`timescale 1ns/1ps

module fhk_housekeeping #(
	parameter int COARSE_TIMEOUT = fhk_pkg::COARSE_TIMEOUT
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic [fhk_pkg::NUM_FIB*fhk_pkg::ADC_W-1:0] i_adc_data,
	input wire logic i_fine_wr,
	input wire logic [3:0] i_fine_chan,
	input wire logic [fhk_pkg::RAM_W-1:0] i_fine_pos,
	input wire logic i_fine_done,
	input wire logic [fhk_pkg::ADDR_W-1:0] i_addr,
	input wire logic [fhk_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [fhk_pkg::DATA_W-1:0] o_rdata,
	output logic o_dly_wr,
	output logic [3:0] o_dly_chan,
	output logic [fhk_pkg::DLY_W-1:0] o_dly_value,
	output logic o_coarse_busy,
	output logic [fhk_pkg::NUM_FIB-1:0] o_start_pulse,
	output logic [fhk_pkg::NUM_FIB-1:0] o_hold_avg
);

	//----------------------------------------
	// helpers
	//----------------------------------------
	// fold a value below three spans back into 0..2239
	function automatic logic [11:0] fhk_wrap(input logic [13:0] v);
		logic [13:0] r;
		r = v;
		if (r >= fhk_pkg::POS_SPAN) begin
			r = r - fhk_pkg::POS_SPAN;
		end
		if (r >= fhk_pkg::POS_SPAN) begin
			r = r - fhk_pkg::POS_SPAN;
		end
		return r[11:0];
	endfunction

	// register index match within a twelve-entry window
	function automatic logic fhk_hit(input logic [7:0] a, input logic [7:0] base);
		return (a >= base) && (a < base + 8'h0c);
	endfunction

	localparam logic [fhk_pkg::TMO_W-1:0] TMO_LAST = fhk_pkg::TMO_W'(COARSE_TIMEOUT - 1);

	//----------------------------------------
	// state
	//----------------------------------------
	logic [fhk_pkg::RAM_W-1:0] ram_q [fhk_pkg::NUM_FIB];
	logic [2:0] ctrl_q;
	logic [fhk_pkg::SPOS_W-1:0] spos_q;
	logic done_q, abort_q, halted_q;
	fhk_pkg::fhk_coarse_t cs_q;
	logic [fhk_pkg::TMO_W-1:0] tmo_q;
	logic [3:0] send_q;
	logic [4:0] slot_q;
	logic [fhk_pkg::ACC_W-1:0] acc_dc_q [fhk_pkg::NUM_FIB];
	logic [fhk_pkg::ACC_W-1:0] acc_lo_q [fhk_pkg::NUM_FIB];
	logic [fhk_pkg::ACC_W-1:0] acc_hi_q [fhk_pkg::NUM_FIB];
	logic [fhk_pkg::ADC_W-1:0] thr_q [fhk_pkg::NUM_FIB];
	fhk_pkg::fhk_tick_t ts_q [fhk_pkg::NUM_FIB];
	logic [6:0] tick_q [fhk_pkg::NUM_FIB];
	logic [fhk_pkg::NUM_FIB-1:0] frame_q;
	logic [8:0] fcnt_q [fhk_pkg::NUM_FIB];
	logic [17:0] hdr_q [fhk_pkg::NUM_FIB];

	//----------------------------------------
	// per-fibre coarse arithmetic
	//----------------------------------------
	logic [11:0] prep_val [fhk_pkg::NUM_FIB];
	logic [11:0] step_val [fhk_pkg::NUM_FIB];
	logic [fhk_pkg::NUM_FIB-1:0] fib_zero, fib_low;

	for (genvar f = 0; f < fhk_pkg::NUM_FIB; f++) begin : g_arith
		wire logic [13:0] pos = {2'h0, ram_q[f][11:0]};
		wire logic [13:0] inv = fhk_pkg::POS_INV - pos;
		wire logic [13:0] sum = 14'(fhk_wrap(inv)) + 14'(spos_q);
		wire logic valid = ram_q[f][fhk_pkg::VALID_BIT];
		assign prep_val[f] = fhk_wrap(sum) ^ fhk_pkg::POS_XOR;
		assign step_val[f] = fhk_wrap(pos + fhk_pkg::POS_SPAN - fhk_pkg::POS_STEP);
		assign fib_zero[f] = valid && (ram_q[f][11:0] == 12'h000);
		assign fib_low[f] = !valid || (ram_q[f][11:0] < fhk_pkg::POS_LIMIT);
	end

	// solution: one valid entry at zero, all valid inside the coarse span
	wire logic solved = (|fib_zero) && (&fib_low);
	wire logic timed_out = (tmo_q == TMO_LAST);

	//----------------------------------------
	// register decode
	//----------------------------------------
	wire logic [7:0] a_ram = i_addr - fhk_pkg::A_RAM_BASE;
	wire logic [7:0] a_thr = i_addr - fhk_pkg::A_THR_BASE;
	wire logic [7:0] a_hdr = i_addr - fhk_pkg::A_HDR_BASE;
	wire logic hit_ram = fhk_hit(i_addr, fhk_pkg::A_RAM_BASE);
	wire logic hit_thr = fhk_hit(i_addr, fhk_pkg::A_THR_BASE);
	wire logic hit_hdr = fhk_hit(i_addr, fhk_pkg::A_HDR_BASE);
	wire logic halted = (cs_q == fhk_pkg::CS_IDLE);
	// host RAM writes only while the procedure stands still
	wire logic ram_wr = i_wr && hit_ram && halted;
	wire logic ctrl_wr = i_wr && (i_addr == fhk_pkg::A_CTRL);
	wire logic go_fine = i_fine_done && ctrl_q[fhk_pkg::CTRL_AUTO];
	wire logic go_sw = ctrl_wr && i_wdata[fhk_pkg::CTRL_RUN];
	wire logic go = halted && (go_fine || go_sw);
	wire logic filt_en = ctrl_q[fhk_pkg::CTRL_FILT];

	logic [fhk_pkg::NUM_FIB-1:0] lock_vec;
	for (genvar f = 0; f < fhk_pkg::NUM_FIB; f++) begin : g_lock
		assign lock_vec[f] = (ts_q[f] == fhk_pkg::TS_LOCKED);
	end

	logic [fhk_pkg::DATA_W-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		if (hit_ram) begin
			rd_mux = 32'(ram_q[a_ram[3:0]]);
		end else if (hit_thr) begin
			rd_mux = 32'(thr_q[a_thr[3:0]]);
		end else if (hit_hdr) begin
			rd_mux = 32'(hdr_q[a_hdr[3:0]]);
		end else if (i_addr == fhk_pkg::A_CTRL) begin
			rd_mux = 32'(ctrl_q);
		end else if (i_addr == fhk_pkg::A_SPOS) begin
			rd_mux = 32'(spos_q);
		end else if (i_addr == fhk_pkg::A_STAT) begin
			rd_mux = {28'h0000000, halted_q, abort_q, done_q, !halted};
		end else if (i_addr == fhk_pkg::A_LOCK) begin
			rd_mux = 32'(lock_vec);
		end
	end

	// read data valid the cycle after the strobe, zero otherwise
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= i_rd ? rd_mux : '0;
		end
	end

	// control and sample-offset registers
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			ctrl_q <= fhk_pkg::CTRL_RST;
			spos_q <= '0;
		end else begin
			if (ctrl_wr) begin
				ctrl_q <= {1'b0, i_wdata[1:0]};
			end
			if (i_wr && (i_addr == fhk_pkg::A_SPOS)) begin
				spos_q <= i_wdata[fhk_pkg::SPOS_W-1:0];
			end
		end
	end

	//----------------------------------------
	// position RAM
	//----------------------------------------
	// host and fine pass write while idle, procedure rewrites in place
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			for (int i = 0; i < fhk_pkg::NUM_FIB; i++) begin
				ram_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < fhk_pkg::NUM_FIB; i++) begin
				if (cs_q == fhk_pkg::CS_PREP) begin
					ram_q[i][11:0] <= prep_val[i];
				end else if (cs_q == fhk_pkg::CS_STEP && !solved && !timed_out) begin
					ram_q[i][11:0] <= step_val[i];
				end else if (ram_wr && a_ram[3:0] == 4'(i)) begin
					ram_q[i] <= i_wdata[fhk_pkg::RAM_W-1:0];
				end else if (halted && i_fine_wr && i_fine_chan == 4'(i)) begin
					ram_q[i] <= i_fine_pos;
				end
			end
		end
	end

	//----------------------------------------
	// coarse procedure sequencer
	//----------------------------------------
	wire logic send_end = (send_q == 4'(fhk_pkg::NUM_FIB - 1));

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			cs_q <= fhk_pkg::CS_IDLE;
			tmo_q <= '0;
			send_q <= '0;
			done_q <= 1'b0;
			abort_q <= 1'b0;
			halted_q <= 1'b0;
		end else begin
			unique case (cs_q)
				fhk_pkg::CS_IDLE: begin
					if (go) begin
						cs_q <= fhk_pkg::CS_PREP;
						tmo_q <= '0;
						done_q <= 1'b0;
						abort_q <= 1'b0;
						halted_q <= 1'b0;
					end
					if (i_fine_done && !ctrl_q[fhk_pkg::CTRL_AUTO]) begin
						halted_q <= 1'b1;
					end
				end
				fhk_pkg::CS_PREP: begin
					cs_q <= fhk_pkg::CS_STEP;
					tmo_q <= tmo_q + 1'b1;
				end
				fhk_pkg::CS_STEP: begin
					tmo_q <= tmo_q + 1'b1;
					if (solved) begin
						cs_q <= fhk_pkg::CS_SEND;
						send_q <= '0;
					end else if (timed_out) begin
						cs_q <= fhk_pkg::CS_IDLE;
						abort_q <= 1'b1;
					end
				end
				fhk_pkg::CS_SEND: begin
					send_q <= send_end ? 4'h0 : send_q + 4'h1; // stays a valid ram index
					if (send_end) begin
						cs_q <= fhk_pkg::CS_IDLE;
						done_q <= 1'b1;
					end
				end
			endcase
		end
	end

	// one delay-chip load per valid fibre, in fibre order
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_dly_wr <= 1'b0;
			o_dly_chan <= '0;
			o_dly_value <= '0;
			o_coarse_busy <= 1'b0;
		end else begin
			o_coarse_busy <= !(cs_q == fhk_pkg::CS_IDLE && !go) &&
				!(cs_q == fhk_pkg::CS_SEND && send_end) &&
				!(cs_q == fhk_pkg::CS_STEP && !solved && timed_out);
			o_dly_wr <= (cs_q == fhk_pkg::CS_SEND) && ram_q[send_q][fhk_pkg::VALID_BIT];
			o_dly_chan <= send_q;
			o_dly_value <= ram_q[send_q][fhk_pkg::DLY_W-1:0];
		end
	end

	//----------------------------------------
	// threshold filters
	//----------------------------------------
	// shared slot counter: three averages each served once per 32 cycles
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			slot_q <= '0;
		end else begin
			slot_q <= slot_q + 1'b1;
		end
	end

	logic [fhk_pkg::NUM_FIB-1:0] bit_one;

	for (genvar f = 0; f < fhk_pkg::NUM_FIB; f++) begin : g_filt
		wire logic [fhk_pkg::ADC_W-1:0] smp = i_adc_data[f*fhk_pkg::ADC_W +: fhk_pkg::ADC_W];
		wire logic [fhk_pkg::ADC_W:0] dc_lvl = {1'b0, acc_dc_q[f][fhk_pkg::ACC_W-1 -: fhk_pkg::ADC_W]};
		wire logic [fhk_pkg::ADC_W:0] split = dc_lvl + fhk_pkg::THR_OFS;
		wire logic below = {1'b0, smp} < split;
		wire logic above = {1'b0, smp} > split;
		// frozen by the user or held during frames; skipped updates leave the weight intact
		wire logic run = filt_en && !o_hold_avg[f];
		// the single datapath: one accumulator chosen per slot
		wire logic [fhk_pkg::ACC_W-1:0] acc_sel = (slot_q == fhk_pkg::SLOT_DC) ? acc_dc_q[f] :
			(slot_q == fhk_pkg::SLOT_LO) ? acc_lo_q[f] : acc_hi_q[f];
		wire logic [fhk_pkg::ACC_W-1:0] acc_new = acc_sel - (acc_sel >> fhk_pkg::IIR_SHIFT) +
			fhk_pkg::ACC_W'(smp);
		wire logic [fhk_pkg::ADC_W:0] thr_sum = {1'b0, acc_lo_q[f][fhk_pkg::ACC_W-1 -: fhk_pkg::ADC_W]} +
			{1'b0, acc_hi_q[f][fhk_pkg::ACC_W-1 -: fhk_pkg::ADC_W]};

		always_ff @(posedge i_sys_clk or posedge i_reset) begin
			if (i_reset) begin
				acc_dc_q[f] <= fhk_pkg::ACC_LO_RST;
				acc_lo_q[f] <= fhk_pkg::ACC_LO_RST;
				acc_hi_q[f] <= fhk_pkg::ACC_HI_RST;
				thr_q[f] <= '0;
			end else begin
				if (run && slot_q == fhk_pkg::SLOT_DC) begin
					acc_dc_q[f] <= acc_new;
				end
				if (run && slot_q == fhk_pkg::SLOT_LO && below) begin
					acc_lo_q[f] <= acc_new;
				end
				if (run && slot_q == fhk_pkg::SLOT_HI && above) begin
					acc_hi_q[f] <= acc_new;
				end
				thr_q[f] <= thr_sum[fhk_pkg::ADC_W:1];
			end
		end

		assign bit_one[f] = smp > thr_q[f];
	end

	//----------------------------------------
	// tick monitors
	//----------------------------------------
	for (genvar f = 0; f < fhk_pkg::NUM_FIB; f++) begin : g_tick
		wire logic b = bit_one[f];
		wire logic [6:0] tnext = (tick_q[f] == fhk_pkg::TICK_LAST) ? 7'h00 : tick_q[f] + 7'h01;
		wire logic tick_ph = (tick_q[f] <= 7'h01);
		wire logic hdr_ph = (tick_q[f] == fhk_pkg::TICK_HDR);
		wire logic in_ones = frame_q[f] && fcnt_q[f] <= fhk_pkg::HDR_ONES_LAST;
		wire logic ones_done = frame_q[f] && fcnt_q[f] == fhk_pkg::HDR_ONES_LAST && b;
		wire logic frame_end = frame_q[f] && fcnt_q[f] == fhk_pkg::FRAME_LAST;

		// lock search, confirmation and frame tracking
		always_ff @(posedge i_sys_clk or posedge i_reset) begin
			if (i_reset) begin
				ts_q[f] <= fhk_pkg::TS_SEARCH;
				tick_q[f] <= '0;
				frame_q[f] <= 1'b0;
				fcnt_q[f] <= '0;
				hdr_q[f] <= '0;
				o_start_pulse[f] <= 1'b0;
				o_hold_avg[f] <= 1'b0;
			end else begin
				tick_q[f] <= tnext;
				o_start_pulse[f] <= ones_done;
				o_hold_avg[f] <= frame_q[f] && !frame_end;
				unique case (ts_q[f])
					fhk_pkg::TS_SEARCH: begin
						// first high sample taken as phase 0
						if (b) begin
							ts_q[f] <= fhk_pkg::TS_CONFIRM;
						end
						tick_q[f] <= b ? 7'h01 : 7'h00;
					end
					fhk_pkg::TS_CONFIRM: begin
						if (tick_ph && !b) begin
							ts_q[f] <= fhk_pkg::TS_SEARCH;
							tick_q[f] <= '0;
						end else if (tick_q[f] == 7'h01 && tick_q[f] != 7'h00 && b &&
							fcnt_q[f] == 9'h001) begin
							ts_q[f] <= fhk_pkg::TS_LOCKED;
						end
						// second tick seen marks the confirming period
						if (tick_q[f] == fhk_pkg::TICK_LAST) begin
							fcnt_q[f] <= 9'h001;
						end else if (tick_q[f] == 7'h01) begin
							fcnt_q[f] <= '0;
						end
					end
					fhk_pkg::TS_LOCKED: begin
						if (!frame_q[f]) begin
							if (tick_ph && !b) begin
								ts_q[f] <= fhk_pkg::TS_SEARCH;
								tick_q[f] <= '0;
							end else if (hdr_ph && b) begin
								frame_q[f] <= 1'b1;
								fcnt_q[f] <= 9'h001;
							end
						end else begin
							fcnt_q[f] <= fcnt_q[f] + 9'h001;
							if (in_ones && !b) begin
								frame_q[f] <= 1'b0; // not a header after all
								fcnt_q[f] <= '0;
							end else if (fcnt_q[f] > fhk_pkg::HDR_ONES_LAST &&
								fcnt_q[f] <= fhk_pkg::ERR_LAST) begin
								hdr_q[f] <= {hdr_q[f][16:0], b};
							end
							if (frame_end) begin
								frame_q[f] <= 1'b0;
								fcnt_q[f] <= '0;
							end
						end
					end
				endcase
			end
		end
	end

endmodule

// File: fhk_pkg.sv
// constants shared by the fibre housekeeping block
// assumes twelve fibres of 10-bit samples and one 40 MHz clock

package fhk_pkg;

	//----------------------------------------
	// geometry
	//----------------------------------------
	localparam int NUM_FIB = 12;
	localparam int ADC_W = 10;
	localparam int POS_W = 12;
	localparam int RAM_W = 13;
	localparam int VALID_BIT = 12; // 4096 marks a valid, zeroed entry
	localparam int DLY_W = 9;
	localparam int SPOS_W = 11;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	//----------------------------------------
	// coarse procedure figures
	//----------------------------------------
	localparam logic [13:0] POS_SPAN = 14'h08c0; // 70 x 32
	localparam logic [13:0] POS_INV = 14'h0c80; // 3200
	localparam logic [13:0] POS_STEP = 14'h0020; // 32
	localparam logic [11:0] POS_LIMIT = 12'h200; // 512
	localparam logic [11:0] POS_XOR = 12'h01f; // low five bits
	localparam int COARSE_SPAN = 16;
	localparam int COARSE_TIMEOUT = 8192;
	localparam int TMO_W = 14;

	//----------------------------------------
	// threshold filter figures
	//----------------------------------------
	localparam int IIR_SHIFT = 10;
	localparam int ACC_W = 20;
	localparam logic [ADC_W:0] THR_OFS = 11'h032; // 50 counts
	localparam logic [4:0] UPD_LAST = 5'h1f; // 32-cycle update period
	localparam logic [4:0] SLOT_DC = 5'h00;
	localparam logic [4:0] SLOT_LO = 5'h01;
	localparam logic [4:0] SLOT_HI = 5'h02;
	localparam logic [ACC_W-1:0] ACC_LO_RST = 20'h00000;
	localparam logic [ACC_W-1:0] ACC_HI_RST = 20'hffc00;

	//----------------------------------------
	// tick monitor figures
	//----------------------------------------
	localparam logic [6:0] TICK_LAST = 7'h45; // 70-cycle period
	localparam logic [6:0] TICK_HDR = 7'h02;
	localparam logic [8:0] HDR_ONES_LAST = 9'h003; // four ones
	localparam logic [8:0] ADDR_LAST = 9'h013; // 16 address samples
	localparam logic [8:0] ERR_LAST = 9'h015; // 2 error samples
	localparam logic [8:0] FRAME_LAST = 9'h115; // 278 cycles to next tick

	//----------------------------------------
	// register map, byte lanes unused
	//----------------------------------------
	localparam logic [ADDR_W-1:0] A_RAM_BASE = 8'h00;
	localparam logic [ADDR_W-1:0] A_CTRL = 8'h10;
	localparam logic [ADDR_W-1:0] A_SPOS = 8'h11;
	localparam logic [ADDR_W-1:0] A_STAT = 8'h12;
	localparam logic [ADDR_W-1:0] A_LOCK = 8'h13;
	localparam logic [ADDR_W-1:0] A_THR_BASE = 8'h20;
	localparam logic [ADDR_W-1:0] A_HDR_BASE = 8'h30;
	localparam int CTRL_AUTO = 0;
	localparam int CTRL_FILT = 1;
	localparam int CTRL_RUN = 2;
	localparam logic [2:0] CTRL_RST = 3'h2;

	//----------------------------------------
	// states
	//----------------------------------------
	typedef enum logic [3:0] {
		CS_IDLE = 4'h1,
		CS_PREP = 4'h2,
		CS_STEP = 4'h4,
		CS_SEND = 4'h8
	} fhk_coarse_t;

	typedef enum logic [2:0] {
		TS_SEARCH = 3'h1,
		TS_CONFIRM = 3'h2,
		TS_LOCKED = 3'h4
	} fhk_tick_t;

endpackage

// File: fhk_monitor.sv
// checker on the housekeeping ports
// assumes one clock, bound onto fhk_housekeeping
`timescale 1ns/1ps

module fhk_monitor #(
	parameter int COARSE_TIMEOUT = 8192
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic [fhk_pkg::ADDR_W-1:0] i_addr,
	input wire logic [fhk_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [fhk_pkg::DATA_W-1:0] o_rdata,
	input wire logic o_dly_wr,
	input wire logic [3:0] o_dly_chan,
	input wire logic o_coarse_busy,
	input wire logic [fhk_pkg::NUM_FIB-1:0] o_start_pulse,
	input wire logic [fhk_pkg::NUM_FIB-1:0] o_hold_avg
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	logic [15:0] busy_cnt_q;

	// length of the running coarse pass
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			busy_cnt_q <= 16'h0000;
		end else begin
			busy_cnt_q <= o_coarse_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
		end
	end

	//----------------------------------------
	// properties
	//----------------------------------------
	sequence s_run_req;
		i_wr && (i_addr == fhk_pkg::A_CTRL) && i_wdata[fhk_pkg::CTRL_RUN] && !o_coarse_busy;
	endsequence
	sequence s_busy_soon;
		##[1:2] o_coarse_busy;
	endsequence
	property p_rd_zero;
		!$past(i_rd) |-> (o_rdata == '0);
	endproperty
	property p_run;
		s_run_req |-> s_busy_soon;
	endproperty
	property p_dly_chan;
		o_dly_wr |-> (o_dly_chan < 4'hc);
	endproperty
	property p_dly_busy;
		o_dly_wr |-> $past(o_coarse_busy);
	endproperty
	property p_run_len;
		busy_cnt_q <= COARSE_TIMEOUT + 16;
	endproperty
	property p_pulse_once;
		(o_start_pulse != '0) |=> ((o_start_pulse & $past(o_start_pulse)) == '0);
	endproperty
	property p_pulse_hold;
		o_start_pulse[0] |-> o_hold_avg[0];
	endproperty
	property p_hold_len;
		o_start_pulse[0] |=> o_hold_avg[0] [*8];
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("read data outside read slot");
	a_run: assert property (p_run) else $error("coarse start not taken");
	a_dly_chan: assert property (p_dly_chan) else $error("delay channel out of range");
	a_dly_busy: assert property (p_dly_busy) else $error("delay load outside coarse pass");
	a_run_len: assert property (p_run_len) else $error("coarse pass not cut short");
	a_pulse_once: assert property (p_pulse_once) else $error("start pulse longer than one cycle");
	a_pulse_hold: assert property (p_pulse_hold) else $error("start pulse without hold");
	a_hold_len: assert property (p_hold_len) else $error("hold dropped early");
endmodule

bind fhk_housekeeping fhk_monitor #(.COARSE_TIMEOUT(COARSE_TIMEOUT)) u_mon (
	.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_dly_wr(o_dly_wr), .o_dly_chan(o_dly_chan),
	.o_coarse_busy(o_coarse_busy), .o_start_pulse(o_start_pulse), .o_hold_avg(o_hold_avg)
);

// File: fhk_far_side.sv
// far side: twelve sample streams and the delay chips
// assumes the same clock as the block
`timescale 1ns/1ps

module fhk_far_side (
	input wire logic i_sys_clk,
	input wire logic i_frame_req,
	input wire logic i_dly_wr,
	input wire logic [3:0] i_dly_chan,
	input wire logic [fhk_pkg::DLY_W-1:0] i_dly_value,
	output logic [fhk_pkg::NUM_FIB*fhk_pkg::ADC_W-1:0] o_adc_data
);
	localparam logic [17:0] HDR = 18'h2970f;
	int phase = 0;
	int fc = -1;
	int dly_cnt = 0;
	logic [11:0] dly_mask = 12'h000;
	logic [8:0] dly_seen [12];
	logic hi;

	// tick every 70, frame of four ticks on request
	always @(posedge i_sys_clk) begin
		if (fc >= 0) begin
			fc <= (fc == 279) ? -1 : fc + 1;
		end else if (i_frame_req && phase == 69) begin
			fc <= 0;
		end
		phase <= (phase == 69) ? 0 : phase + 1;
	end

	// tick, four ones, header then low data words
	assign hi = (fc < 0) ? (phase < 2) : (fc < 6 || (fc < 24 && HDR[23-fc]));
	assign o_adc_data = {12{hi ? 10'h3e8 : 10'h064}};

	// delay chips keep each loaded value
	always @(posedge i_sys_clk) begin
		if (i_dly_wr) begin
			dly_seen[i_dly_chan] <= i_dly_value;
			dly_mask[i_dly_chan] <= 1'b1;
			dly_cnt <= dly_cnt + 1;
		end
	end
endmodule

// File: testbench.sv
// register-port sequences against the housekeeping block
// assumes fhk_pkg, design, far side and checker compiled first
`timescale 1ns/1ps

module testbench;
	logic i_sys_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [119:0] adc;
	logic i_fine_done = 1'b0;
	logic i_fine_wr = 1'b0;
	logic [3:0] i_fine_chan = 4'h0;
	logic [12:0] i_fine_pos = 13'h0000;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic frame_req = 1'b0;
	logic [31:0] o_rdata;
	logic o_dly_wr;
	logic [3:0] o_dly_chan;
	logic [8:0] o_dly_value;
	logic o_coarse_busy;
	logic [11:0] o_start_pulse;
	logic [11:0] o_hold_avg;
	logic [31:0] rd_v;
	logic [31:0] t1;
	logic [8:0] exp_dly [12];
	logic [11:0] vmask = 12'hff7;
	int pos [12];
	int failures = 0;
	int samples_checked = 0;

	initial begin
		forever #12.5 i_sys_clk = ~i_sys_clk;
	end

	fhk_housekeeping #(.COARSE_TIMEOUT(64)) uut (
		.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_adc_data(adc), .i_fine_wr(i_fine_wr),
		.i_fine_chan(i_fine_chan), .i_fine_pos(i_fine_pos), .i_fine_done(i_fine_done), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_dly_wr(o_dly_wr),
		.o_dly_chan(o_dly_chan), .o_dly_value(o_dly_value), .o_coarse_busy(o_coarse_busy),
		.o_start_pulse(o_start_pulse), .o_hold_avg(o_hold_avg)
	);
	fhk_far_side u_far (
		.i_sys_clk(i_sys_clk), .i_frame_req(frame_req), .i_dly_wr(o_dly_wr),
		.i_dly_chan(o_dly_chan), .i_dly_value(o_dly_value), .o_adc_data(adc)
	);

	//----------------------------------------
	// bus and compare tasks
	//----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		samples_checked++;
		if (seen !== expv) begin
			$display("BAD %0t seen %h exp %h", $time, seen, expv);
			failures++;
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] expv);
		logic [31:0] d;
		rd(a, d);
		check(d, expv);
	endtask
	task automatic pulse_done;
		@(posedge i_sys_clk);
		i_fine_done <= 1'b1;
		@(posedge i_sys_clk);
		i_fine_done <= 1'b0;
	endtask
	// bounded wait, busy low or start pulse seen
	task automatic wait_for(input bit pulse);
		int n;
		for (n = 0; n < 400; n++) begin
			@(posedge i_sys_clk);
			#1;
			if (pulse ? (o_start_pulse !== 12'h000) : (o_coarse_busy === 1'b0)) break;
		end
		if (n == 400) begin
			failures++;
			end_sim();
		end
	endtask
	// expected delay words of one coarse pass
	task automatic calc(input int spos);
		int x [12];
		bit z;
		bit ok;
		for (int f = 0; f < 12; f++) begin
			x[f] = 3200 - pos[f];
			x[f] = (x[f] >= 2240) ? x[f] - 2240 : x[f];
			x[f] = x[f] + spos;
			x[f] = (x[f] >= 2240) ? x[f] - 2240 : x[f];
			x[f] = x[f] ^ 31;
		end
		for (int s = 0; s < 200; s++) begin
			z = 0;
			ok = 1;
			for (int f = 0; f < 12; f++) begin
				if (vmask[f] && x[f] == 0) z = 1;
				if (vmask[f] && x[f] >= 512) ok = 0;
			end
			if (z && ok) break;
			for (int f = 0; f < 12; f++) x[f] = (x[f] < 32) ? x[f] + 2208 : x[f] - 32;
		end
		for (int f = 0; f < 12; f++) exp_dly[f] = 9'(x[f]);
	endtask
	task automatic end_sim;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	//----------------------------------------
	// main sequence
	//----------------------------------------
	initial begin
		repeat (3) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		rdchk(fhk_pkg::A_CTRL, 32'h2);
		rdchk(fhk_pkg::A_STAT, 32'h0);
		rdchk(8'h40, 32'h0);
		for (int f = 0; f < 12; f++) wr(8'(f), 32'h1000);
		rdchk(8'h05, 32'h1000);
		// fine pass lands one word while idle
		@(posedge i_sys_clk);
		i_fine_wr <= 1'b1;
		i_fine_chan <= 4'h2;
		i_fine_pos <= 13'h18bf;
		@(posedge i_sys_clk);
		i_fine_wr <= 1'b0;
		rdchk(8'h02, 32'h18bf);
		pulse_done();
		rdchk(fhk_pkg::A_STAT, 32'h8);
		for (int f = 0; f < 12; f++) pos[f] = (f == 3) ? 1000 : 32 * (20 + f) + 1;
		for (int f = 0; f < 12; f++) wr(8'(f), 32'(pos[f]) | (vmask[f] ? 32'h1000 : 32'h0));
		wr(fhk_pkg::A_SPOS, 32'h60);
		wr(fhk_pkg::A_CTRL, 32'h3);
		calc(96);
		pulse_done();
		repeat (2) @(posedge i_sys_clk);
		wait_for(0);
		// last delay load reaches the chips a cycle after busy drops
		repeat (2) @(posedge i_sys_clk);
		check(32'(u_far.dly_cnt), 32'd11);
		check(32'(u_far.dly_mask), 32'hff7);
		for (int f = 0; f < 12; f++) if (vmask[f]) check(32'(u_far.dly_seen[f]), 32'(exp_dly[f]));
		rdchk(fhk_pkg::A_STAT, 32'h2);
		for (int f = 0; f < 12; f++) wr(8'(f), (f == 0) ? 32'h1001 : (f == 1) ? 32'h1461 : 32'h0);
		wr(fhk_pkg::A_CTRL, 32'h7);
		wr(8'h05, 32'h1234);
		wait_for(0);
		check(32'(u_far.dly_cnt), 32'd11);
		rd(fhk_pkg::A_STAT, rd_v);
		check(rd_v & 32'h4, 32'h4);
		rd(8'h05, rd_v);
		check(32'(rd_v === 32'h1234), 32'h0);
		repeat (400) @(posedge i_sys_clk);
		rdchk(fhk_pkg::A_LOCK, 32'hfff);
		rd(fhk_pkg::A_THR_BASE, t1);
		check(32'(t1 > 32'd100 && t1 < 32'd1000), 32'h1);
		wr(fhk_pkg::A_CTRL, 32'h0);
		rd(fhk_pkg::A_THR_BASE, t1);
		repeat (100) @(posedge i_sys_clk);
		rdchk(fhk_pkg::A_THR_BASE, t1);
		frame_req <= 1'b1;
		wait_for(1);
		frame_req <= 1'b0;
		check(32'(o_start_pulse), 32'hfff);
		check(32'(o_hold_avg), 32'hfff);
		@(posedge i_sys_clk);
		#1;
		check(32'(o_start_pulse), 32'h0);
		repeat (40) @(posedge i_sys_clk);
		rdchk(fhk_pkg::A_HDR_BASE, 32'h2970f);
		repeat (300) @(posedge i_sys_clk);
		#1;
		check(32'(o_hold_avg), 32'h0);
		rdchk(fhk_pkg::A_LOCK, 32'hfff);
		end_sim();
	end
endmodule
